//--- common/csc_window_consts.vh
// Offsets, field positions, reset values and codes of the socket control bank
`ifndef CSC_WINDOW_CONSTS_VH
`define CSC_WINDOW_CONSTS_VH

// Legacy index offsets for socket A; socket B sits at the base below
`define IDX_STATUS        8'h04
`define IDX_CONFIG        8'h05
`define IDX_WINDOW        8'h06
`define IDX_SOCKB_BASE    8'h40
`define IDX_SOCK_BIT      6

// Memory-mapped offsets from the socket base
`define MAP_STATUS        12'h804
`define MAP_CONFIG        12'h805
`define MAP_WINDOW        12'h806

// Register selector codes
`define SEL_STATUS        2'h0
`define SEL_CONFIG        2'h1
`define SEL_WINDOW        2'h2

// Reset values
`define CONFIG_RESET      8'h00
`define WINDOW_RESET      8'h00
`define STATUS_RESET      4'h0

// Writable bits of the window enable register, bit 5 reserved
`define WINDOW_RW_MASK    8'hDF

// Config register fields
`define ROUTE_MSB         7
`define ROUTE_LSB         4
`define CD_EN_BIT         3
`define READY_EN_BIT      2
`define BATWARN_EN_BIT    1
`define BATDEAD_EN_BIT    0

// Window enable fields
`define IOWIN1_BIT        7
`define IOWIN0_BIT        6
`define MEMWIN_MSB        4

// Routing codes
`define ROUTE_PCI         4'h0
`define ROUTE_IRQ1        4'h1
`define ROUTE_SYS_MGMT    4'h2

`endif

//--- hw/csc_window_bank.v
// Two-socket status-change interrupt configuration and window enable bank
`include "csc_window_consts.vh"

// Overview of operation
// RQ1: Config bits 7-4 select status-change delivery target.
// RQ2: Code 0000 with diag bit set: PCI.
// RQ3: Code 0000, diag clear: PCI only if enabled.
// RQ4: 0001 IRQ1, 0010 system management, others IRQ number.
// RQ5: 1110 means IRQ14, 1111 means IRQ15.
// RQ6: Bit 3 enables card-detect change interrupts.
// RQ7: Bit 2 enables READY rising-edge interrupts.
// RQ8: Bit 1 enables battery warning interrupts.
// RQ9: Bit 0 enables battery dead/status-change interrupts.
// RQ10: Disabled window never claims a cycle.
// RQ11: Window enable register resets to 00h.
// RQ12: Bits 7 and 6 enable I/O windows.
// RQ13: Bits 4-0 enable memory windows 4-0.
// RQ14: Window bit 5 reads zero, ignores writes.
// RQ15: Separate registers per socket, legacy and mapped.
// RQ16: Disabled source reads zero in status.
// RQ17: Flags clear by read or write-one.

// Registers are reached by legacy index, where bit 6 picks the socket,
// or by mapped offset, where regSocket picks the socket base.
// Reads answer one cycle after the strobe; writes have no answer.
// Card pins are asynchronous and are synchronised before any use.
// Limitation: with clearByWrite low, a status read clears every flag of that socket.
// Trade-off: claims lag hits by one cycle so every output is a flop.

module csc_window_bank (
   input  wire        mclk,
   input  wire        resetn,
   // Register access port
   // Strobes are one-cycle pulses; a read and a write in one cycle both act
   input  wire        regRead,
   input  wire        regWrite,
   input  wire        regMapped,
   input  wire        regSocket,
   input  wire [11:0] regAddr,
   input  wire [7:0]  regWriteData,
   output reg  [7:0]  readData,
   output reg         readValid,
   // Loose control bits from other registers
   // They share this clock, so they need no synchroniser
   input  wire        diagRouteToPci,
   input  wire [1:0]  pciRouteEnable,
   input  wire        clearByWrite,
   // Card pins, one bit per socket
   // Asynchronous; each passes two flops before any logic reads it
   input  wire [1:0]  card_detect_line_one,
   input  wire [1:0]  card_detect_line_two,
   input  wire [1:0]  cardReady,
   input  wire [1:0]  batteryWarning,
   input  wire [1:0]  card_status_change_signal,
   // Window hits from address comparators, socket B in upper half
   // Comparators run on this clock, so hits are used as they come
   input  wire [9:0]  memWinHit,
   input  wire [3:0]  ioWinHit,
   // Interrupt delivery
   // Levels, one cycle behind the flags
   output reg  [1:0]  pciIntReq,
   output reg         system_management_interrupt,
   output reg  [15:0] isaIrq,
   // Cycle claims per window
   // One cycle behind the hits
   output reg  [9:0]  memWinClaim,
   output reg  [3:0]  ioWinClaim
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   // Returns {valid, socket, selector}; shared by read and write paths.
   // Legacy indices with any upper bit set fall through as unmapped, so a
   // stray wide address reads 00h instead of aliasing onto a register.
   function [3:0] decode;
      input        mapped;
      input        sock;
      input [11:0] addr;
      reg   [7:0]  low;
      begin
         decode = 4'h0;
         // Socket bit masked out so both sockets share one compare
         low = {1'b0, addr[6:0]} & ~(8'h01 << `IDX_SOCK_BIT);
         if (mapped) begin
            if (addr == `MAP_STATUS || addr == `MAP_CONFIG || addr == `MAP_WINDOW) begin // RQ15
               decode = {1'b1, sock, addr[1:0]};
            end
         end else if (addr[11:7] == 5'h00) begin
            if (low == `IDX_STATUS || low == `IDX_CONFIG || low == `IDX_WINDOW) begin // RQ15
               decode = {1'b1, addr[`IDX_SOCK_BIT], low[1:0]};
            end
         end
      end
   endfunction

   wire [3:0] dec      = decode(regMapped, regSocket, regAddr);
   wire       decValid = dec[3];
   wire       decSock  = dec[2];
   wire [1:0] decSel   = dec[1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge history

   // Packed as {status, warn, ready, cd2, cd1} per socket pair
   wire [9:0] pinRaw = {card_status_change_signal, batteryWarning, cardReady,
                        card_detect_line_two, card_detect_line_one};
   reg  [9:0] pinMeta;
   reg  [9:0] pinSync;
   reg  [9:0] pinPrev;

   // Two stages before use; pinMeta feeds pinSync only.
   // pinPrev is the history for edge detection, never a third sync stage.
   // All stages reset low like the idle pins, so no false edge follows reset;
   // a card already present still shows one edge, but enables reset to zero.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pinMeta <= 10'h000;
         pinSync <= 10'h000;
         pinPrev <= 10'h000;
      end else begin
         pinMeta <= pinRaw;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-socket registers and flags

   // Socket copies seen from outside the generate loop
   wire [7:0] cfgA;
   wire [7:0] cfgB;
   wire [7:0] winA;
   wire [7:0] winB;
   wire [3:0] visA;
   wire [3:0] visB;
   wire [15:0] irqVecA;
   wire [15:0] irqVecB;
   wire [1:0] mgmtVec;
   wire [1:0] pciVec;

   // One copy of registers, flags and routing per socket; results are
   // handed out through named wires because a generate scope has no slices.
   genvar s;
   generate
      for (s = 0; s < 2; s = s + 1) begin : sock
         reg  [7:0] cfg;
         reg  [7:0] win;
         reg  [3:0] flag;
         reg  [3:0] next_flag;
         reg  [15:0] irqVec;
         reg        mgmt;
         reg        pci;
         wire       hitMe = decValid && (decSock == s);
         // Any change of either detect line; rising edges for the rest
         wire       cdEv  = (pinSync[s] ^ pinPrev[s]) | (pinSync[2 + s] ^ pinPrev[2 + s]);
         wire       rdyEv = pinSync[4 + s] & ~pinPrev[4 + s];
         wire       wrnEv = pinSync[6 + s] & ~pinPrev[6 + s];
         wire       dedEv = pinSync[8 + s] & ~pinPrev[8 + s];
         // Sources in status bit order: detect, ready, warning, dead
         wire [3:0] en    = {cfg[`CD_EN_BIT], cfg[`READY_EN_BIT],
                             cfg[`BATWARN_EN_BIT], cfg[`BATDEAD_EN_BIT]};
         wire [3:0] ev    = {cdEv, rdyEv, wrnEv, dedEv};
         wire [3:0] vis   = flag & en; // RQ16
         wire [3:0] route = cfg[`ROUTE_MSB:`ROUTE_LSB];

         // Writes to config and window enable; reserved window bit never stored.
         // Masking on the way in keeps the read path free of special cases.
         always @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               cfg <= `CONFIG_RESET; // RQ6 RQ7 RQ8 RQ9
               win <= `WINDOW_RESET; // RQ11
            end else if (regWrite && hitMe) begin
               if (decSel == `SEL_CONFIG) begin
                  cfg <= regWriteData; // RQ1
               end
               if (decSel == `SEL_WINDOW) begin
                  win <= regWriteData & `WINDOW_RW_MASK; // RQ14
               end
            end
         end

         // Flag update: a new event beats a clear in the same cycle.
         // Starting from the masked flags drops a source as soon as its enable
         // clears, so turning it back on never raises a stale interrupt.
         // Read-clear takes every flag of the socket that was read.
         always @* begin
            next_flag = vis;
            if (hitMe && decSel == `SEL_STATUS) begin
               if (clearByWrite && regWrite) begin
                  next_flag = next_flag & ~regWriteData[3:0]; // RQ17
               end else if (!clearByWrite && regRead) begin
                  next_flag = 4'h0; // RQ17
               end
            end
            next_flag = next_flag | (ev & en); // RQ6 RQ7 RQ8 RQ9
         end

         // Flag storage
         always @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               flag <= `STATUS_RESET;
            end else begin
               flag <= next_flag;
            end
         end

         // Delivery target for this socket's pending change.
         // Codes 0 and 2 never reach the legacy lines, so IRQ0 and IRQ2 stay
         // quiet; 1110 and 1111 give IRQ14 and IRQ15 by plain shifting.
         always @* begin
            irqVec = 16'h0000;
            mgmt   = 1'b0;
            pci    = 1'b0;
            if (|vis) begin
               if (route == `ROUTE_PCI) begin
                  pci = diagRouteToPci | pciRouteEnable[s]; // RQ2 RQ3
               end else if (route == `ROUTE_SYS_MGMT) begin
                  mgmt = 1'b1; // RQ4
               end else begin
                  irqVec = 16'h0001 << route; // RQ4 RQ5
               end
            end
         end

         // Per-socket results leave the generate scope here
         assign pciVec[s] = pci;
         assign mgmtVec[s] = mgmt;
         if (s == 0) begin : outA
            assign cfgA    = cfg;
            assign winA    = win;
            assign visA    = vis;
            assign irqVecA = irqVec;
         end else begin : outB
            assign cfgB    = cfg;
            assign winB    = win;
            assign visB    = vis;
            assign irqVecB = irqVec;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Next answer, built from the decode of this cycle
   reg [7:0] next_readData;

   // Status reads show only enabled sources; an unmapped address still
   // answers with 00h, so software polling a hole never stalls.
   always @* begin
      next_readData = 8'h00;
      if (decValid) begin
         // Selector codes follow the low two offset bits
         case (decSel)
            `SEL_STATUS: next_readData = {4'h0, decSock ? visB : visA}; // RQ16
            `SEL_CONFIG: next_readData = decSock ? cfgB : cfgA;
            `SEL_WINDOW: next_readData = decSock ? winB : winA; // RQ14
            default:     next_readData = 8'h00;
         endcase
      end
   end

   // Registered answer; data idles at 00h so a shared read bus stays clean
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         readData  <= 8'h00;
         readValid <= 1'b0;
      end else begin
         readData  <= regRead ? next_readData : 8'h00;
         readValid <= regRead;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt outputs and window claims, all registered

   // Enables gathered in hit order: socket A in the low half of each vector
   wire [9:0] memEn = {winB[`MEMWIN_MSB:0], winA[`MEMWIN_MSB:0]};
   wire [3:0] ioEn  = {winB[`IOWIN1_BIT], winB[`IOWIN0_BIT],
                       winA[`IOWIN1_BIT], winA[`IOWIN0_BIT]};

   // Claims lag hits by one cycle; the address comparators must hold a hit
   // through the cycle in which it is to be claimed. Interrupts are levels
   // that stand while any enabled flag of a socket is set.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pciIntReq                   <= 2'h0;
         system_management_interrupt <= 1'b0;
         isaIrq                      <= 16'h0000;
         memWinClaim                 <= 10'h000;
         ioWinClaim                  <= 4'h0;
      end else begin
         pciIntReq                   <= pciVec; // RQ2 RQ3
         system_management_interrupt <= |mgmtVec; // RQ4
         isaIrq                      <= irqVecA | irqVecB; // RQ4 RQ5
         memWinClaim                 <= memWinHit & memEn; // RQ10 RQ13
         ioWinClaim                  <= ioWinHit & ioEn; // RQ10 RQ12
      end
   end

endmodule

//--- test/card_pin_model.sv
// Card side model driving detect, READY, battery and status-change pins
module card_pin_model (
   input wire logic  mclk,
   output logic [1:0] cdOne,
   output logic [1:0] cdTwo,
   output logic [1:0] ready,
   output logic [1:0] batWarn,
   output logic [1:0] statusChg
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {cdOne, cdTwo, ready, batWarn, statusChg} = 10'h000;
   end
   // Detect only toggles, any change counts; others pulse, only the rise counts
   task automatic fire(input int src, input int s);
      case (src)
         3: cdOne[s] = ~cdOne[s];
         2: ready[s] = 1'b1;
         1: batWarn[s] = 1'b1;
         default: statusChg[s] = 1'b1;
      endcase
      repeat (3) @(posedge mclk);
      #1 {ready[s], batWarn[s], statusChg[s]} = 3'b000;
   endtask
endmodule

//--- test/csc_window_bank_asserts.sv
// Concurrent checks on the ports of the socket control bank
module csc_window_bank_asserts (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        regRead,
   input wire logic        regWrite,
   input wire logic [11:0] regAddr,
   input wire logic [7:0]  readData,
   input wire logic        readValid,
   input wire logic [9:0]  memWinHit,
   input wire logic [3:0]  ioWinHit,
   input wire logic [15:0] isaIrq,
   input wire logic [9:0]  memWinClaim,
   input wire logic [3:0]  ioWinClaim
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Read answer timing; data bus idles at zero so stale values never leak
   chk_read_answer: assert property (regRead |=> readValid)
      else $error("read not answered");
   chk_valid_cause: assert property (readValid |-> $past(regRead))
      else $error("answer without read");
   chk_idle_data: assert property (!readValid |-> readData == 8'h00)
      else $error("read data not idle");
   chk_write_quiet: assert property (regWrite && !regRead |=> !readValid)
      else $error("write answered");
   // A claim needs a hit on the cycle before
   chk_mem_claim: assert property ((memWinClaim & ~$past(memWinHit)) == 10'h000)
      else $error("memory claim without hit");
   chk_io_claim: assert property ((ioWinClaim & ~$past(ioWinHit)) == 4'h0)
      else $error("io claim without hit");
   chk_reserved_bit: assert property (regRead && regAddr[5:0] == 6'h06 |=> !readData[5])
      else $error("reserved window bit set");
   chk_unused_irq: assert property (!isaIrq[0] && !isaIrq[2])
      else $error("unused irq line driven");
   // Hits taken on the release edge meet closed windows one cycle later
   chk_reset_quiet: assert property ($rose(resetn) |=> memWinClaim == 10'h000
      && ioWinClaim == 4'h0 && isaIrq == 16'h0000)
      else $error("outputs busy after reset");
endmodule

bind csc_window_bank csc_window_bank_asserts chk (.mclk, .resetn, .regRead, .regWrite,
   .regAddr, .readData, .readValid, .memWinHit, .ioWinHit, .isaIrq, .memWinClaim, .ioWinClaim);

//--- test/csc_window_bank_tb_top.sv
// Self-checking bench for the socket control bank
module csc_window_bank_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk = 0, resetn = 0, regRead = 0, regWrite = 0, regMapped = 0;
   logic        regSocket = 0, diagRouteToPci = 0, clearByWrite = 0, readValid, sysMgmt;
   logic [1:0]  pciRouteEnable = 0, pciIntReq, cdOne, cdTwo, ready, batWarn, statusChg;
   logic [11:0] regAddr = 0;
   logic [7:0]  regWriteData = 0, readData;
   logic [9:0]  memWinHit = 0, memWinClaim;
   logic [3:0]  ioWinHit = 0, ioWinClaim;
   logic [15:0] isaIrq;
   int          err_count = 0, n_checks = 0;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch at %0t got %h exp %h", $time, a, b); end end

   always #5 mclk = ~mclk;

   csc_window_bank dut (.mclk(mclk), .resetn(resetn), .regRead(regRead), .regWrite(regWrite),
      .regMapped(regMapped), .regSocket(regSocket), .regAddr(regAddr),
      .regWriteData(regWriteData), .readData(readData), .readValid(readValid),
      .diagRouteToPci(diagRouteToPci), .pciRouteEnable(pciRouteEnable),
      .clearByWrite(clearByWrite), .card_detect_line_one(cdOne),
      .card_detect_line_two(cdTwo), .cardReady(ready), .batteryWarning(batWarn),
      .card_status_change_signal(statusChg), .memWinHit(memWinHit), .ioWinHit(ioWinHit),
      .pciIntReq(pciIntReq), .system_management_interrupt(sysMgmt), .isaIrq(isaIrq),
      .memWinClaim(memWinClaim), .ioWinClaim(ioWinClaim));
   card_pin_model pins (.mclk(mclk), .cdOne(cdOne), .cdTwo(cdTwo), .ready(ready),
      .batWarn(batWarn), .statusChg(statusChg));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // One strobe cycle; strobes drop after the taking edge
   task automatic acc(input logic r, m, s, input logic [11:0] a, input logic [7:0] d);
      cyc(1);
      {regRead, regWrite, regMapped, regSocket, regAddr, regWriteData} = {r, !r, m, s, a, d};
      cyc(1);
      {regRead, regWrite} = 2'b00;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      acc(0, 0, 0, a, d);
   endtask
   task automatic rd(input logic m, s, input logic [11:0] a, input logic [7:0] e);
      acc(1, m, s, a, 8'h00);
      `CHK(readValid, 1'b1)
      `CHK(readData, e)
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about five microseconds
   initial begin
      #50us;
      err_count++;
      wrap_up;
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [3:0]  en, c;
      logic [17:0] ex;
      cyc(10);
      resetn = 1;
      rd(0, 0, 12'h005, 8'h00);
      rd(0, 0, 12'h006, 8'h00);
      rd(0, 0, 12'h045, 8'h00);
      rd(1, 1, 12'h806, 8'h00);
      rd(0, 0, 12'h00F, 8'h00);
      $display("test reset done");
      // Both sockets kept apart, reserved bit never stored
      wr(12'h006, 8'hFF);
      wr(12'h046, 8'hA5);
      rd(0, 0, 12'h006, 8'hDF);
      rd(1, 0, 12'h806, 8'hDF);
      rd(1, 1, 12'h806, 8'h85);
      {memWinHit, ioWinHit} = 14'h3FFF;
      cyc(1);
      `CHK(memWinClaim, 10'h0BF)
      `CHK(ioWinClaim, 4'hB)
      wr(12'h006, 8'h00);
      cyc(1);
      `CHK(memWinClaim, 10'h0A0)
      `CHK(ioWinClaim, 4'h8)
      {memWinHit, ioWinHit} = 14'h0000;
      $display("test windows done");
      // Each source enabled then masked, cleared by writing one
      clearByWrite = 1;
      for (int j = 0; j < 8; j++) begin
         en = (j < 4) ? 4'h1 << j : 4'h0;
         wr(12'h005, {4'h3, en});
         pins.fire(j % 4, 0);
         cyc(4);
         `CHK(isaIrq, (j < 4) ? 16'h0008 : 16'h0000)
         rd(0, 0, 12'h004, {4'h0, en});
         wr(12'h004, {4'h0, en});
         cyc(3);
         `CHK(isaIrq, 16'h0000)
      end
      $display("test sources done");
      // Every routing code plus the PCI cases, cleared by status read
      clearByWrite = 0;
      for (int k = 0; k < 18; k++) begin
         c = (k < 16) ? k[3:0] : 4'h0;
         diagRouteToPci = (k == 0);
         pciRouteEnable = {1'b0, k == 17};
         ex = (c == 0) ? {k != 16, 17'h0} : (c == 2) ? 18'h10000 : {2'b0, 16'h1 << c};
         wr(12'h005, {c, 4'h4});
         rd(0, 0, 12'h005, {c, 4'h4});
         pins.fire(2, 0);
         cyc(4);
         `CHK({pciIntReq[0], sysMgmt, isaIrq}, ex)
         rd(0, 0, 12'h004, 8'h04);
         cyc(3);
         `CHK({pciIntReq[0], sysMgmt, isaIrq}, 18'h0)
      end
      $display("test routing done");
      // Socket B change on its own PCI request, mapped access, per-socket clear
      pciRouteEnable = 2'b10;
      acc(0, 1, 1, 12'h805, 8'h08);
      rd(1, 1, 12'h805, 8'h08);
      pins.fire(3, 1);
      cyc(4);
      `CHK({pciIntReq, sysMgmt, isaIrq}, 19'h40000)
      rd(0, 0, 12'h004, 8'h00);
      rd(1, 1, 12'h804, 8'h08);
      cyc(3);
      `CHK(pciIntReq, 2'b00)
      $display("test socket b done");
      // Reset in mid-run with windows open and hits held
      wr(12'h006, 8'hFF);
      wr(12'h046, 8'hFF);
      {memWinHit, ioWinHit} = 14'h3FFF;
      cyc(1);
      `CHK({memWinClaim, ioWinClaim}, 14'h3FFF)
      resetn = 0;
      cyc(2);
      `CHK({memWinClaim, ioWinClaim, pciIntReq, isaIrq}, 32'h0)
      resetn = 1;
      cyc(1);
      `CHK({memWinClaim, ioWinClaim}, 14'h0000)
      {memWinHit, ioWinHit} = 14'h0000;
      rd(0, 0, 12'h006, 8'h00);
      rd(1, 1, 12'h806, 8'h00);
      rd(0, 0, 12'h005, 8'h00);
      rd(1, 1, 12'h805, 8'h00);
      $display("test reset again done");
      wrap_up;
   end
endmodule
